//--- verilog/mtc_regs.sv
// Motor timer, captures, compare, weight multiplier and interrupt gating.
// Assumes one AHB-Lite master, synchronous event pulses from motor logic on hclk,
// and the processor's global mask given as a level on the same clock.
//
// Design decisions made here: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
module mtc_regs #(
    parameter int PRESCALE_W = 4
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Motor-side events and capture source
    input wire mtc_pkg::mtc_evt_s events,
    input wire logic [7:0] demag_capture_val,
    input wire logic global_irq_masked,
    // Interrupt vector requests
    output logic [2:0] irq_req,
    // Views for the motor logic
    output logic [7:0] next_commutation_compare,
    output logic [3:0] current_sense_rate,
    output logic [3:0] timer_prescale_ratio,
    output logic step_tick
);
    mtc_pkg::mtc_state_s st_r;
    mtc_pkg::mtc_state_s st_nxt;
    // Prescaler divider for the step timer
    logic [15:0] div_r;
    logic [15:0] div_nxt;

    // Decoded write strobe for one register offset
    function automatic logic wr_hit(input mtc_pkg::mtc_aph_s a, input logic [7:0] off);
        return a.valid && a.write && (a.addr == off);
    endfunction

    // Decoded read strobe, used at the address phase
    function automatic logic rd_hit(input logic take, input logic wr, input logic [7:0] ad,
                                    input logic [7:0] off);
        return take && !wr && (ad == off);
    endfunction

    logic take;
    logic [7:0] wb;
    logic auto_mode;
    logic speed_mode;
    logic [15:0] prod;
    logic [15:0] cnt16;
    logic [7:0] pend;
    logic div_done;

    // Always ready, always OKAY: every access finishes in one wait-free data phase
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = {24'h000000, st_r.rdata};
    assign irq_req = st_r.irq;
    assign next_commutation_compare = st_r.comp;
    assign current_sense_rate = st_r.prescale[mtc_pkg::MTC_SA_HI:mtc_pkg::MTC_SA_LO];
    assign timer_prescale_ratio = st_r.prescale[mtc_pkg::MTC_ST_HI:mtc_pkg::MTC_ST_LO];
    assign step_tick = div_done;

    assign take = hsel && hready && htrans[mtc_pkg::MTC_HTRANS_NSQ];
    assign wb = hwdata[7:0];
    assign auto_mode = st_r.ctrl[mtc_pkg::MTC_CTL_AUTO];
    assign speed_mode = st_r.ctrl[mtc_pkg::MTC_CTL_SPEED];
    assign cnt16 = {st_r.tmr_hi, st_r.tmr_lo};
    // Multiplier source picked by the weight source select bit; the capture being taken on this
    // zero-cross is the live timer, and the one it pushes into the previous slot is today's current
    assign prod = (st_r.ctrl[mtc_pkg::MTC_CTL_WSRC] ? st_r.cur_cap : st_r.tmr_hi) * st_r.weight;
    // Timer advances once per 2^ratio clocks; larger ratio slows the step timer.
    // Greater-or-equal so that lowering the ratio takes effect at once instead of after a wrap
    assign div_done = (div_r >= ((16'h0001 << timer_prescale_ratio) - 16'h0001));

    // Prescale divider
    always_comb begin
        div_nxt = div_done ? 16'h0000 : div_r + 16'h0001;
    end

    // Next-state logic for the whole block
    always_comb begin
        st_nxt = st_r;
        // Capture the address phase for the following data phase
        if (hready) begin
            st_nxt.aph.valid = take;
            st_nxt.aph.write = hwrite;
            st_nxt.aph.addr = haddr[7:0];
        end
        // Read data is registered in the address phase
        if (take && !hwrite) begin
            case (haddr[7:0])
                mtc_pkg::MTC_OFF_TIMER: st_nxt.rdata = st_r.tmr_hi;
                mtc_pkg::MTC_OFF_TIMER_LOW: st_nxt.rdata = st_r.tmr_lo;
                mtc_pkg::MTC_OFF_PREV_CAP: st_nxt.rdata = st_r.prev_cap;
                mtc_pkg::MTC_OFF_CUR_CAP: st_nxt.rdata = st_r.cur_cap;
                mtc_pkg::MTC_OFF_COMP: st_nxt.rdata = st_r.comp;
                mtc_pkg::MTC_OFF_DEMAG: st_nxt.rdata = st_r.demag;
                mtc_pkg::MTC_OFF_WEIGHT: st_nxt.rdata = st_r.weight;
                mtc_pkg::MTC_OFF_PRESCALE: st_nxt.rdata = st_r.prescale;
                mtc_pkg::MTC_OFF_MASK: st_nxt.rdata = st_r.mask;
                mtc_pkg::MTC_OFF_STATUS: st_nxt.rdata = st_r.status;
                mtc_pkg::MTC_OFF_CTRL: st_nxt.rdata = st_r.ctrl;
                default: st_nxt.rdata = 8'h00; // Unmapped reads as zero
            endcase
        end
        // Step timer: 8-bit normally, 16-bit pair in speed mode
        if (div_done) begin
            if (speed_mode) begin
                {st_nxt.tmr_hi, st_nxt.tmr_lo} = cnt16 + 16'h0001;
            end else begin
                st_nxt.tmr_hi = st_r.tmr_hi + 8'h01;
            end
        end
        // Software writes override the count
        if (wr_hit(st_r.aph, mtc_pkg::MTC_OFF_TIMER)) begin
            st_nxt.tmr_hi = wb;
        end
        if (wr_hit(st_r.aph, mtc_pkg::MTC_OFF_TIMER_LOW)) begin
            st_nxt.tmr_lo = wb;
        end
        // Plain register writes
        if (wr_hit(st_r.aph, mtc_pkg::MTC_OFF_PREV_CAP)) begin
            st_nxt.prev_cap = wb;
        end
        if (wr_hit(st_r.aph, mtc_pkg::MTC_OFF_CUR_CAP)) begin
            st_nxt.cur_cap = wb;
        end
        if (wr_hit(st_r.aph, mtc_pkg::MTC_OFF_COMP)) begin
            st_nxt.comp = wb;
        end
        if (wr_hit(st_r.aph, mtc_pkg::MTC_OFF_DEMAG)) begin
            st_nxt.demag = wb;
        end
        if (wr_hit(st_r.aph, mtc_pkg::MTC_OFF_WEIGHT)) begin
            st_nxt.weight = wb;
        end
        if (wr_hit(st_r.aph, mtc_pkg::MTC_OFF_PRESCALE)) begin
            st_nxt.prescale = wb;
        end
        if (wr_hit(st_r.aph, mtc_pkg::MTC_OFF_MASK)) begin
            st_nxt.mask = wb;
        end
        if (wr_hit(st_r.aph, mtc_pkg::MTC_OFF_CTRL)) begin
            st_nxt.ctrl = wb;
        end
        // Ratio events step the prescale field; it saturates rather than wrapping
        if (events.ratio_up && !events.ratio_down && st_r.prescale[3:0] != 4'hf) begin
            st_nxt.prescale[3:0] = st_r.prescale[3:0] + 4'h1;
        end else if (events.ratio_down && !events.ratio_up && st_r.prescale[3:0] != 4'h0) begin
            st_nxt.prescale[3:0] = st_r.prescale[3:0] - 4'h1;
        end
        // Capture handling
        if (speed_mode) begin
            // Reading the high capture freezes captures until the low one is read
            if (rd_hit(take, hwrite, haddr[7:0], mtc_pkg::MTC_OFF_CUR_CAP)) begin
                st_nxt.cap_hold = 1'b1;
            end
            if (rd_hit(take, hwrite, haddr[7:0], mtc_pkg::MTC_OFF_PREV_CAP)) begin
                st_nxt.cap_hold = 1'b0;
            end
            if (!st_r.cap_hold && (events.zero_cross ||
                (st_r.ctrl[mtc_pkg::MTC_CTL_SWCAP] &&
                 rd_hit(take, hwrite, haddr[7:0], mtc_pkg::MTC_OFF_TIMER)))) begin
                st_nxt.cur_cap = st_r.tmr_hi;
                st_nxt.prev_cap = st_r.tmr_lo;
            end
        end else begin
            st_nxt.cap_hold = 1'b0;
            if (events.zero_cross) begin
                st_nxt.prev_cap = st_r.cur_cap;
                st_nxt.cur_cap = st_r.tmr_hi;
                if (auto_mode) begin
                    st_nxt.comp = prod[15:8];
                end
            end
            // Hardware demag detection stores the captured value
            if (events.demag_capture && st_r.ctrl[mtc_pkg::MTC_CTL_HDM]) begin
                st_nxt.demag = demag_capture_val;
            end
        end
        // Status flags: software writes load the byte, or only clear bits written 0 in autoswitched mode; hardware set wins
        if (wr_hit(st_r.aph, mtc_pkg::MTC_OFF_STATUS)) begin
            st_nxt.status = auto_mode ? (st_r.status & wb) : wb;
        end
        st_nxt.status[mtc_pkg::MTC_BIT_PWM] = st_nxt.status[mtc_pkg::MTC_BIT_PWM] | events.pwm_update;
        st_nxt.status[mtc_pkg::MTC_ST_UP] = st_nxt.status[mtc_pkg::MTC_ST_UP] | events.ratio_up;
        st_nxt.status[mtc_pkg::MTC_ST_DOWN] = st_nxt.status[mtc_pkg::MTC_ST_DOWN] | events.ratio_down;
        st_nxt.status[mtc_pkg::MTC_BIT_CURRENT_LIMIT_ENABLE] = st_nxt.status[mtc_pkg::MTC_BIT_CURRENT_LIMIT_ENABLE] |
            (events.current_limit && !st_r.ctrl[mtc_pkg::MTC_CTL_VMODE_CUR]);
        st_nxt.status[mtc_pkg::MTC_BIT_ESTOP] = st_nxt.status[mtc_pkg::MTC_BIT_ESTOP] | events.estop;
        st_nxt.status[mtc_pkg::MTC_BIT_ZERO] = st_nxt.status[mtc_pkg::MTC_BIT_ZERO] | events.zero_cross;
        st_nxt.status[mtc_pkg::MTC_BIT_DEMAG] = st_nxt.status[mtc_pkg::MTC_BIT_DEMAG] | events.demag_end;
        st_nxt.status[mtc_pkg::MTC_BIT_COMM] = st_nxt.status[mtc_pkg::MTC_BIT_COMM] | events.commutation;
        // Interrupt vectors follow registered pending flags
        st_nxt.irq[0] = !global_irq_masked && (pend[7] | pend[5] | pend[3]);
        st_nxt.irq[1] = !global_irq_masked && (pend[2] | pend[1] | pend[0]);
        st_nxt.irq[2] = !global_irq_masked && (pend[6] | pend[4]);
    end

    // Speed error flag lives beside the status byte since the status layout has no slot
    logic speed_err_r;
    logic speed_match;
    // Speed-mode match of demag register against the live timer
    assign speed_match = speed_mode && (st_r.tmr_hi == st_r.demag) && (st_r.demag != 8'h00);

    // Pending-and-enabled terms, one per interrupt source
    always_comb begin
        pend[7] = st_r.status[mtc_pkg::MTC_BIT_PWM] & st_r.mask[mtc_pkg::MTC_BIT_PWM];
        pend[6] = speed_err_r & st_r.mask[mtc_pkg::MTC_BIT_SPEED];
        pend[5] = (st_r.status[mtc_pkg::MTC_ST_UP] | st_r.status[mtc_pkg::MTC_ST_DOWN]) &
                  st_r.mask[mtc_pkg::MTC_BIT_RATIO];
        pend[4] = st_r.status[mtc_pkg::MTC_BIT_CURRENT_LIMIT_ENABLE] & st_r.mask[mtc_pkg::MTC_BIT_CURRENT_LIMIT_ENABLE] &
                  !st_r.ctrl[mtc_pkg::MTC_CTL_VMODE_CUR];
        pend[3] = st_r.status[mtc_pkg::MTC_BIT_ESTOP] & st_r.mask[mtc_pkg::MTC_BIT_ESTOP];
        pend[2] = st_r.status[mtc_pkg::MTC_BIT_ZERO] & st_r.mask[mtc_pkg::MTC_BIT_ZERO];
        pend[1] = st_r.status[mtc_pkg::MTC_BIT_DEMAG] & st_r.mask[mtc_pkg::MTC_BIT_DEMAG] &
                  (st_r.ctrl[mtc_pkg::MTC_CTL_HDM] | st_r.ctrl[mtc_pkg::MTC_CTL_SDM]);
        pend[0] = st_r.status[mtc_pkg::MTC_BIT_COMM] & st_r.mask[mtc_pkg::MTC_BIT_COMM];
    end

    // Speed error flag: set by match, cleared by writing 1 to control bit 7; set wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            speed_err_r <= 1'b0;
        end else if (speed_match) begin
            speed_err_r <= 1'b1;
        end else if (wr_hit(st_r.aph, mtc_pkg::MTC_OFF_CTRL) && wb[7]) begin
            speed_err_r <= 1'b0;
        end
    end

    // State register; every field resets to zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '0;
            div_r <= 16'h0000;
        end else begin
            st_r <= st_nxt;
            div_r <= div_nxt;
        end
    end

    // Requests drop when the global mask is set
    irq_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(global_irq_masked) |=> (irq_req == 3'b000)) else $error("irq while masked");
    // Zero-cross in autoswitched mode loads compare from product
    auto_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (events.zero_cross && auto_mode && !speed_mode) |=> (next_commutation_compare == $past(prod[15:8])))
        else $error("compare not loaded");
    // Ratio-up steps the prescale field by one
    ratio_up_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (events.ratio_up && !events.ratio_down && timer_prescale_ratio != 4'hf &&
         !wr_hit(st_r.aph, mtc_pkg::MTC_OFF_PRESCALE))
        |=> timer_prescale_ratio == $past(timer_prescale_ratio) + 4'h1) else $error("ratio up");
    // Ratio-down steps the prescale field down by one
    ratio_dn_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (events.ratio_down && !events.ratio_up && timer_prescale_ratio != 4'h0 &&
         !wr_hit(st_r.aph, mtc_pkg::MTC_OFF_PRESCALE))
        |=> timer_prescale_ratio == $past(timer_prescale_ratio) - 4'h1) else $error("ratio down");
    // Held captures do not move
    cap_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_r.cap_hold && speed_mode && !st_r.aph.write) |=> $stable(st_r.cur_cap)) else $error("capture moved");
    // Current-limit flag never sets in current mode
    current_limit_enable_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (events.current_limit && st_r.ctrl[mtc_pkg::MTC_CTL_VMODE_CUR] && !st_r.status[4]
         && !wr_hit(st_r.aph, mtc_pkg::MTC_OFF_STATUS)) |=> !st_r.status[4]) else $error("current_limit_enable set");
    // Enabled zero-cross raises vector 1 two cycles later
    zero_irq_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (events.zero_cross && st_r.mask[2] && !global_irq_masked) ##1 (!global_irq_masked && st_r.mask[2]
         && !wr_hit(st_r.aph, mtc_pkg::MTC_OFF_STATUS)) |=> irq_req[1]) else $error("no zero irq");
    // Speed match sets speed error
    speed_err_a: assert property (@(posedge hclk) disable iff (!hresetn)
        speed_match |=> speed_err_r) else $error("speed error lost");
endmodule

//--- verilog/mtc_pkg.sv
// Package for the motor timer, capture and interrupt-gating slice.
// Assumes an AHB-Lite slave with 32-bit data; each 8-bit register sits in one word.
package mtc_pkg;
    // Register byte offsets (word aligned)
    localparam logic [7:0] MTC_OFF_TIMER = 8'h00;
    localparam logic [7:0] MTC_OFF_TIMER_LOW = 8'h04;
    localparam logic [7:0] MTC_OFF_PREV_CAP = 8'h08;
    localparam logic [7:0] MTC_OFF_CUR_CAP = 8'h0c;
    localparam logic [7:0] MTC_OFF_COMP = 8'h10;
    localparam logic [7:0] MTC_OFF_DEMAG = 8'h14;
    localparam logic [7:0] MTC_OFF_WEIGHT = 8'h18;
    localparam logic [7:0] MTC_OFF_PRESCALE = 8'h1c;
    localparam logic [7:0] MTC_OFF_MASK = 8'h20;
    localparam logic [7:0] MTC_OFF_STATUS = 8'h24;
    localparam logic [7:0] MTC_OFF_CTRL = 8'h28;
    // Common reset value of every register
    localparam logic [7:0] MTC_RST_BYTE = 8'h00;
    // Mask and status bit positions
    localparam int MTC_BIT_PWM = 7;
    localparam int MTC_BIT_SPEED = 6;
    localparam int MTC_BIT_RATIO = 5;
    localparam int MTC_BIT_CURRENT_LIMIT_ENABLE = 4;
    localparam int MTC_BIT_ESTOP = 3;
    localparam int MTC_BIT_ZERO = 2;
    localparam int MTC_BIT_DEMAG = 1;
    localparam int MTC_BIT_COMM = 0;
    // Status positions differing from mask layout
    localparam int MTC_ST_UP = 6;
    localparam int MTC_ST_DOWN = 5;
    // Prescaler fields
    localparam int MTC_SA_HI = 7;
    localparam int MTC_SA_LO = 4;
    localparam int MTC_ST_HI = 3;
    localparam int MTC_ST_LO = 0;
    // Control register bit positions
    localparam int MTC_CTL_AUTO = 0;
    localparam int MTC_CTL_SPEED = 1;
    localparam int MTC_CTL_VMODE_CUR = 2;
    localparam int MTC_CTL_WSRC = 3;
    localparam int MTC_CTL_HDM = 4;
    localparam int MTC_CTL_SDM = 5;
    localparam int MTC_CTL_SWCAP = 6;
    // AHB transfer type NONSEQ bit
    localparam int MTC_HTRANS_NSQ = 1;

    // Bus address-phase capture
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } mtc_aph_s;

    // Hardware event inputs bundled together
    typedef struct packed {
        logic pwm_update;
        logic speed_tick;
        logic ratio_up;
        logic ratio_down;
        logic current_limit;
        logic estop;
        logic zero_cross;
        logic demag_end;
        logic demag_capture;
        logic commutation;
    } mtc_evt_s;

    // Whole block state
    typedef struct packed {
        mtc_aph_s aph;
        logic [7:0] rdata;
        logic [7:0] tmr_hi;
        logic [7:0] tmr_lo;
        logic [7:0] prev_cap;
        logic [7:0] cur_cap;
        logic [7:0] comp;
        logic [7:0] demag;
        logic [7:0] weight;
        logic [7:0] prescale;
        logic [7:0] mask;
        logic [7:0] status;
        logic [7:0] ctrl;
        logic cap_hold;
        logic [2:0] irq;
    } mtc_state_s;
endpackage

//--- sim/mtc_cpu_model.sv
// Behavioural model of the processor interrupt side facing the motor block.
// Assumes the software request arrives on hclk and the block's vectors are registered levels.
`timescale 1ns/10ps
module mtc_cpu_model (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Software request to set the global mask
    input wire logic sw_mask_set,
    // Vector requests from the block
    input wire logic [2:0] irq_req,
    // Global mask level and vectors the core has seen
    output logic global_irq_masked,
    output logic [2:0] vec_seen
);
    // Mask is set out of reset, as a core starts with interrupts blocked
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            global_irq_masked <= 1'b1;
            vec_seen <= 3'h0;
        end else begin
            global_irq_masked <= sw_mask_set;
            // A vector counts only while the core is unmasked
            vec_seen <= vec_seen | (irq_req & {3{~global_irq_masked}});
        end
    end
endmodule

//--- sim/tb_top.sv
// Self-checking bench for the motor timer, capture and interrupt-gating block.
// Assumes hreadyout feeds hready and the core model supplies the global mask.
`timescale 1ns/10ps
module tb_top;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    mtc_pkg::mtc_evt_s evt = '0;
    logic [7:0] cap_val = 8'h3c; // Value offered to the hardware demag capture
    logic sw_mask = 1'b0;
    logic masked;
    logic [2:0] irq_req;
    logic [2:0] vec_seen;
    logic [7:0] comp_view;
    logic [3:0] sense_view;
    logic [3:0] ratio_view;
    logic step_tick;
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;
    // Free-running 25 MHz clock
    initial begin
        forever #20 hclk = ~hclk;
    end
    mtc_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .events(evt), .demag_capture_val(cap_val),
        .global_irq_masked(masked), .irq_req(irq_req), .next_commutation_compare(comp_view),
        .current_sense_rate(sense_view), .timer_prescale_ratio(ratio_view), .step_tick(step_tick));
    mtc_cpu_model cpu (.hclk(hclk), .hresetn(hresetn), .sw_mask_set(sw_mask), .irq_req(irq_req),
        .global_irq_masked(masked), .vec_seen(vec_seen));
    // Verdict and end of run, reached from the sequence or the watchdog
    task automatic end_sim();
        $display("Errors %0d, compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Watchdog: the whole sequence needs a few hundred cycles
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            end_sim();
        end
    end
    // Byte comparison, four-state exact
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One AHB-Lite single transfer; waits on hready in both phases
    task automatic ahb_xfer(input logic wr, input logic [7:0] addr, input logic [7:0] wd,
                            output logic [7:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, addr};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= {24'h0, wd};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata[7:0];
    endtask
    task automatic wr(input logic [7:0] addr, input logic [7:0] d);
        logic [7:0] x;
        ahb_xfer(1'b1, addr, d, x);
    endtask
    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] x;
        ahb_xfer(1'b0, addr, 8'h00, x);
        chk8(x, exp);
    endtask
    // One-cycle event pulse, given as a one-hot position in the event bundle;
    // an idle edge follows so back-to-back pulses never drive the bundle twice at once
    task automatic pulse(input int pos);
        evt <= mtc_pkg::mtc_evt_s'(10'h1 << pos);
        @(posedge hclk);
        evt <= '0;
        @(posedge hclk);
    endtask
    // Sample the vector lines two edges on, after the flag edge settles, then realign to an edge
    task automatic irq_chk(input logic [2:0] exp);
        repeat (2) @(posedge hclk);
        #1;
        chk8({5'h0, irq_req}, {5'h0, exp});
        @(posedge hclk);
    endtask
    // Every register reads zero after reset; an unmapped place reads zero too.
    // The timer runs at ratio zero from release, so one step has passed when it is sampled
    task automatic t_reset();
        rd_chk(mtc_pkg::MTC_OFF_TIMER, 8'h01);
        for (int a = 4; a <= 'h28; a += 4) rd_chk(8'(a), mtc_pkg::MTC_RST_BYTE);
        rd_chk(8'h30, 8'h00);
    endtask
    // Plain read-write registers, field views and an ignored unmapped write
    task automatic t_rw();
        wr(mtc_pkg::MTC_OFF_TIMER, 8'h40);
        rd_chk(mtc_pkg::MTC_OFF_TIMER, 8'h40);
        chk8({7'h0, hresp}, 8'h00);
        wr(mtc_pkg::MTC_OFF_COMP, 8'ha5);
        wr(mtc_pkg::MTC_OFF_DEMAG, 8'h5a);
        wr(mtc_pkg::MTC_OFF_PRESCALE, 8'hc3);
        wr(8'h30, 8'hff);
        rd_chk(mtc_pkg::MTC_OFF_COMP, 8'ha5);
        chk8(comp_view, 8'ha5);
        rd_chk(mtc_pkg::MTC_OFF_DEMAG, 8'h5a);
        chk8({sense_view, ratio_view}, 8'hc3);
        rd_chk(8'h30, 8'h00);
    endtask
    // Step prescaler: 2^3 clocks per step, then ratio events move the field
    task automatic t_ratio();
        int n;
        wr(mtc_pkg::MTC_OFF_PRESCALE, 8'h03);
        n = 0;
        repeat (80) begin
            @(negedge hclk);
            if (step_tick === 1'b1) n++;
        end
        @(posedge hclk);
        chk8(8'(n), 8'h0a);
        repeat (20) pulse(7);
        rd_chk(mtc_pkg::MTC_OFF_PRESCALE, 8'h0f);
        pulse(6);
        rd_chk(mtc_pkg::MTC_OFF_PRESCALE, 8'h0e);
        wr(mtc_pkg::MTC_OFF_STATUS, 8'h00);
    endtask
    // Each event: masked off, then enabled, then globally blocked, then cleared
    task automatic t_irq();
        int pos[8] = '{9, 7, 6, 4, 3, 0, 5, 2};
        int mb[8] = '{7, 5, 5, 3, 2, 0, 4, 1};
        int sb[8] = '{7, 6, 5, 3, 2, 0, 4, 1};
        logic [2:0] vec[8] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h2};
        wr(mtc_pkg::MTC_OFF_CTRL, 8'h10);
        for (int i = 0; i < 8; i++) begin
            wr(mtc_pkg::MTC_OFF_MASK, ~(8'h1 << mb[i]));
            pulse(pos[i]);
            irq_chk(3'h0);
            rd_chk(mtc_pkg::MTC_OFF_STATUS, 8'h1 << sb[i]);
            wr(mtc_pkg::MTC_OFF_MASK, 8'h1 << mb[i]);
            irq_chk(vec[i]);
            sw_mask <= 1'b1;
            irq_chk(3'h0);
            sw_mask <= 1'b0;
            irq_chk(vec[i]);
            wr(mtc_pkg::MTC_OFF_STATUS, 8'h00);
            irq_chk(3'h0);
        end
        // Current mode suppresses the current-limit request; no demag mode blocks demag end
        wr(mtc_pkg::MTC_OFF_CTRL, 8'h04);
        wr(mtc_pkg::MTC_OFF_MASK, 8'h12);
        pulse(5);
        irq_chk(3'h0);
        pulse(2);
        irq_chk(3'h0);
        wr(mtc_pkg::MTC_OFF_STATUS, 8'h00);
        chk8({5'h0, vec_seen}, 8'h07);
    endtask
    // Autoswitched: flags cannot be set by software; zero-cross reloads the compare
    task automatic t_auto();
        wr(mtc_pkg::MTC_OFF_CTRL, 8'h11);
        wr(mtc_pkg::MTC_OFF_MASK, 8'h04);
        wr(mtc_pkg::MTC_OFF_STATUS, 8'hff);
        rd_chk(mtc_pkg::MTC_OFF_STATUS, 8'h00);
        // Previous capture as source: 80h times 40h over 256 gives 20h
        wr(mtc_pkg::MTC_OFF_CTRL, 8'h19);
        wr(mtc_pkg::MTC_OFF_CUR_CAP, 8'h80);
        wr(mtc_pkg::MTC_OFF_WEIGHT, 8'h40);
        wr(mtc_pkg::MTC_OFF_COMP, 8'h55);
        wr(mtc_pkg::MTC_OFF_TIMER, 8'h33);
        pulse(3);
        irq_chk(3'h2);
        rd_chk(mtc_pkg::MTC_OFF_COMP, 8'h20);
        rd_chk(mtc_pkg::MTC_OFF_PREV_CAP, 8'h80);
        rd_chk(mtc_pkg::MTC_OFF_CUR_CAP, 8'h33);
        // Current capture as source: the new capture 44h times 40h over 256 gives 11h
        wr(mtc_pkg::MTC_OFF_CTRL, 8'h11);
        wr(mtc_pkg::MTC_OFF_TIMER, 8'h44);
        pulse(3);
        rd_chk(mtc_pkg::MTC_OFF_COMP, 8'h11);
        rd_chk(mtc_pkg::MTC_OFF_STATUS, 8'h04);
        wr(mtc_pkg::MTC_OFF_STATUS, 8'hfb);
        rd_chk(mtc_pkg::MTC_OFF_STATUS, 8'h00);
        pulse(1);
        rd_chk(mtc_pkg::MTC_OFF_DEMAG, 8'h3c);
    endtask
    // Speed mode at ratio zero: the pair counts every clock, so captured low bytes follow
    // the two-cycle spacing of back-to-back transfers after the low byte is cleared
    task automatic t_speed();
        wr(mtc_pkg::MTC_OFF_PRESCALE, 8'h00);
        wr(mtc_pkg::MTC_OFF_CTRL, 8'h42);
        wr(mtc_pkg::MTC_OFF_TIMER_LOW, 8'h00);
        wr(mtc_pkg::MTC_OFF_TIMER, 8'h12);
        rd_chk(mtc_pkg::MTC_OFF_TIMER, 8'h12);
        rd_chk(mtc_pkg::MTC_OFF_CUR_CAP, 8'h12);
        rd_chk(mtc_pkg::MTC_OFF_TIMER, 8'h12);
        rd_chk(mtc_pkg::MTC_OFF_PREV_CAP, 8'h02);
        rd_chk(mtc_pkg::MTC_OFF_TIMER, 8'h12);
        rd_chk(mtc_pkg::MTC_OFF_PREV_CAP, 8'h0a);
        // Demag value equal to the live high byte raises the speed error on vector 2
        wr(mtc_pkg::MTC_OFF_DEMAG, 8'h12);
        wr(mtc_pkg::MTC_OFF_MASK, 8'h40);
        irq_chk(3'h4);
        wr(mtc_pkg::MTC_OFF_DEMAG, 8'h00);
        wr(mtc_pkg::MTC_OFF_CTRL, 8'hc2);
        irq_chk(3'h0);
    endtask
    // Main sequence: 16 cycles of reset, then the scenarios in turn
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_rw();
        t_ratio();
        t_irq();
        t_auto();
        t_speed();
        end_sim();
    end
endmodule
